// *** design/pcg_pkg.sv ***
package pcg_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam logic [31:0] SYSCTL_BASE = 32'h400FE000;
	localparam logic [11:0] OFF_RUN_GATE = 12'h100;
	localparam logic [11:0] OFF_SLEEP_GATE = 12'h110;
	localparam logic [11:0] OFF_MODE_CTRL = 12'h1F0;
	localparam logic [11:0] OFF_FAULT_STAT = 12'h1F4;
	localparam int BIT_KEEPER = 6;
	localparam int BIT_WDOG = 3;
	localparam int BIT_AUTO_GATE = 0;
	localparam int BIT_FAULT_KEEPER = 0;
	localparam int BIT_FAULT_WDOG = 1;
	localparam logic [31:0] GATE_RESET = 32'h00000040;
	localparam logic [31:0] GATE_WMASK = 32'h00000048;
	localparam logic [31:0] ZERO_WORD = 32'h00000000;
	localparam logic [31:0] MODE_WMASK = 32'h00000001;

	typedef enum logic [1:0] {
		PCG_RUN = 2'b00,
		PCG_SLEEP = 2'b01,
		PCG_DEEP = 2'b10
	} pcg_pmode_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} pcg_req_s;

	typedef struct packed {
		logic keeper_sel;
		logic wdog_sel;
		logic valid;
	} pcg_unit_acc_s;
endpackage

// *** design/pcg_fault_chk.sv ***
`timescale 1ns/1ps
module pcg_fault_chk
	import pcg_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input pcg_pkg::pcg_unit_acc_s acc_i,
	input wire logic keeper_en_i,
	input wire logic wdog_en_i,
	output logic fault_o,
	output logic [1:0] fault_src_o
);
	wire keeper_bad = acc_i.valid && acc_i.keeper_sel && !keeper_en_i;
	wire wdog_bad = acc_i.valid && acc_i.wdog_sel && !wdog_en_i;
	logic fault_reg;
	logic [1:0] src_reg;

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fault_reg <= 1'b0;
			src_reg <= 2'h0;
		end else if (ce_i) begin
			fault_reg <= keeper_bad || wdog_bad;
			src_reg <= {wdog_bad, keeper_bad};
		end
	end

	assign fault_o = fault_reg;
	assign fault_src_o = src_reg;
endmodule

// *** design/pcg_top.sv ***
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module pcg_top
	import pcg_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire logic [pcg_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [pcg_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [pcg_pkg::DATA_W-1:0] reg_rdata_o,
	input pcg_pkg::pcg_pmode_e pmode_i,
	input wire logic keeper_acc_i,
	input wire logic wdog_acc_i,
	output logic keeper_clock_enable_o,
	output logic watchdog_clock_enable_o,
	output logic bus_fault_o
);
	logic rst_s1_reg;
	logic rst_b_reg;
	pcg_req_s req;
	logic [DATA_W-1:0] run_gate_reg;
	logic [DATA_W-1:0] sleep_gate_reg;
	logic [DATA_W-1:0] mode_reg;
	logic [DATA_W-1:0] fault_stat_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic keeper_en_reg;
	logic wdog_en_reg;
	logic [1:0] fault_src;
	logic fault_pulse;
	pcg_unit_acc_s acc;

	// Reset is released through two flops so release is synchronous.
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_s1_reg <= 1'b0;
			rst_b_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_b_reg <= rst_s1_reg;
		end
	end

	function automatic logic [DATA_W-1:0] masked_write(
		input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v,
		input logic [DATA_W-1:0] wmask
	);
		masked_write = (old_v & ~wmask) | (new_v & wmask);
	endfunction

	assign req = '{addr: reg_addr_i, wdata: reg_wdata_i,
		wr: reg_wr_i, rd: reg_rd_i};
	wire hit_run = req.addr == OFF_RUN_GATE;
	wire hit_sleep = req.addr == OFF_SLEEP_GATE;
	wire hit_mode = req.addr == OFF_MODE_CTRL;
	wire hit_fault = req.addr == OFF_FAULT_STAT;

	wire [DATA_W-1:0] run_next =
		masked_write(run_gate_reg, req.wdata, GATE_WMASK);
	wire [DATA_W-1:0] sleep_next =
		masked_write(sleep_gate_reg, req.wdata, GATE_WMASK);
	wire [DATA_W-1:0] mode_next =
		masked_write(mode_reg, req.wdata, MODE_WMASK);

	wire auto_gating_select = mode_reg[BIT_AUTO_GATE];
	// Deep sleep has no gating register of its own; here it falls back to run.
	wire use_sleep = auto_gating_select && (pmode_i == PCG_SLEEP);
	wire [DATA_W-1:0] active_gate =
		use_sleep ? sleep_gate_reg : run_gate_reg;

	// Writes of one clear a fault flag; a new fault wins over the clear.
	wire [DATA_W-1:0] fault_clr =
		(req.wr && hit_fault) ? req.wdata : ZERO_WORD;
	wire [DATA_W-1:0] fault_set =
		{{(DATA_W-2){1'b0}}, fault_src & {2{fault_pulse}}};
	wire [DATA_W-1:0] fault_next = (fault_stat_reg & ~fault_clr) | fault_set;

	logic [DATA_W-1:0] rd_mux;
	always_comb begin
		if (hit_run) begin
			rd_mux = run_gate_reg;
		end else if (hit_sleep) begin
			rd_mux = sleep_gate_reg;
		end else if (hit_mode) begin
			rd_mux = mode_reg;
		end else if (hit_fault) begin
			rd_mux = fault_stat_reg;
		end else begin
			rd_mux = ZERO_WORD;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_reg) begin
		if (!rst_b_reg) begin
			run_gate_reg <= GATE_RESET;
			sleep_gate_reg <= GATE_RESET;
			mode_reg <= ZERO_WORD;
		end else if (ce_i && req.wr) begin
			if (hit_run) begin
				run_gate_reg <= run_next;
			end else if (hit_sleep) begin
				sleep_gate_reg <= sleep_next;
			end else if (hit_mode) begin
				mode_reg <= mode_next;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_reg) begin
		if (!rst_b_reg) begin
			fault_stat_reg <= ZERO_WORD;
			rdata_reg <= ZERO_WORD;
		end else if (ce_i) begin
			fault_stat_reg <= fault_next;
			rdata_reg <= req.rd ? rd_mux : ZERO_WORD;
		end
	end

	// Enables are registered so gated clocks see glitch-free controls.
	always_ff @(posedge core_clk_i or negedge rst_b_reg) begin
		if (!rst_b_reg) begin
			keeper_en_reg <= GATE_RESET[BIT_KEEPER];
			wdog_en_reg <= GATE_RESET[BIT_WDOG];
		end else if (ce_i) begin
			keeper_en_reg <= active_gate[BIT_KEEPER];
			wdog_en_reg <= active_gate[BIT_WDOG];
		end
	end

	assign acc = '{keeper_sel: keeper_acc_i, wdog_sel: wdog_acc_i,
		valid: keeper_acc_i || wdog_acc_i};

	pcg_fault_chk u_fault (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_reg),
		.ce_i(ce_i),
		.acc_i(acc),
		.keeper_en_i(keeper_en_reg),
		.wdog_en_i(wdog_en_reg),
		.fault_o(fault_pulse),
		.fault_src_o(fault_src)
	);

	assign reg_rdata_o = rdata_reg;
	assign keeper_clock_enable_o = keeper_en_reg;
	assign watchdog_clock_enable_o = wdog_en_reg;
	assign bus_fault_o = fault_pulse;

	a_reset_value: assert property (@(posedge core_clk_i)
		$rose(rst_b_reg) |-> run_gate_reg == GATE_RESET
			&& sleep_gate_reg == GATE_RESET)
		else $error("gating register reset value wrong");

	a_reserved_zero: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_reg)
		((run_gate_reg | sleep_gate_reg) & ~GATE_WMASK) == ZERO_WORD)
		else $error("reserved gating bit set");

	sequence s_run_write;
		ce_i && req.wr && hit_run;
	endsequence

	a_run_write: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_reg)
		s_run_write |=>
			run_gate_reg == ($past(req.wdata) & GATE_WMASK))
		else $error("run gating write lost");

	a_keeper_follow: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_reg)
		ce_i |=> keeper_clock_enable_o == $past(active_gate[BIT_KEEPER]))
		else $error("keeper enable does not follow gating");

	a_wdog_follow: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_reg)
		ce_i |=> watchdog_clock_enable_o == $past(active_gate[BIT_WDOG]))
		else $error("watchdog enable does not follow gating");

	a_sleep_select: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_reg)
		ce_i && auto_gating_select && pmode_i == PCG_SLEEP |=>
			watchdog_clock_enable_o == $past(sleep_gate_reg[BIT_WDOG]))
		else $error("sleep gating not applied");

	a_no_auto_run: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_reg)
		ce_i && !auto_gating_select |=>
			keeper_clock_enable_o == $past(run_gate_reg[BIT_KEEPER]))
		else $error("run gating not applied without auto select");

	a_gated_fault: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_reg)
		ce_i && wdog_acc_i && !watchdog_clock_enable_o |=> bus_fault_o)
		else $error("access to gated unit did not fault");

	a_clocked_ok: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_reg)
		ce_i && (keeper_acc_i || wdog_acc_i)
			&& (!keeper_acc_i || keeper_clock_enable_o)
			&& (!wdog_acc_i || watchdog_clock_enable_o) |=> !bus_fault_o)
		else $error("fault on clocked unit");

	sequence s_sleep_write;
		ce_i && req.wr && hit_sleep;
	endsequence

	a_sleep_write: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_reg)
		s_sleep_write |=>
			sleep_gate_reg == ($past(req.wdata) & GATE_WMASK))
		else $error("sleep gating write lost");

	sequence s_mode_write;
		ce_i && req.wr && hit_mode;
	endsequence

	a_mode_write: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_reg)
		s_mode_write |=>
			mode_reg == ($past(req.wdata) & MODE_WMASK))
		else $error("mode control write lost");

	// A low clock enable must hold every gating, mode and fault register and both enables.
	a_freeze_state: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_reg)
		!ce_i |=> $stable(run_gate_reg) && $stable(sleep_gate_reg)
			&& $stable(mode_reg) && $stable(fault_stat_reg)
			&& $stable(keeper_clock_enable_o)
			&& $stable(watchdog_clock_enable_o))
		else $error("state moved while clock enable low");

	a_run_hold: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_reg)
		!(ce_i && req.wr && hit_run) |=> $stable(run_gate_reg))
		else $error("run gating changed without a write");

	sequence s_read_run;
		ce_i && req.rd && hit_run;
	endsequence

	a_read_run: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_reg)
		s_read_run |=> reg_rdata_o == $past(run_gate_reg))
		else $error("run gating read data wrong");

	a_read_idle: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_reg)
		ce_i && !req.rd |=> reg_rdata_o == ZERO_WORD)
		else $error("read data not cleared after read");

	a_keeper_fault: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_reg)
		ce_i && keeper_acc_i && !keeper_clock_enable_o
			|=> bus_fault_o)
		else $error("access to gated keeper did not fault");

	a_idle_no_fault: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_reg)
		ce_i && !keeper_acc_i && !wdog_acc_i |=> !bus_fault_o)
		else $error("fault without any unit access");

	sequence s_wdog_fault_seen;
		ce_i && bus_fault_o && fault_src[BIT_FAULT_WDOG];
	endsequence

	a_wdog_sticky: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_reg)
		s_wdog_fault_seen |=> fault_stat_reg[BIT_FAULT_WDOG])
		else $error("watchdog fault not recorded");

	sequence s_keeper_fault_seen;
		ce_i && bus_fault_o && fault_src[BIT_FAULT_KEEPER];
	endsequence

	a_keeper_sticky: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_reg)
		s_keeper_fault_seen |=> fault_stat_reg[BIT_FAULT_KEEPER])
		else $error("keeper fault not recorded");

	a_fault_clear: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_reg)
		ce_i && req.wr && hit_fault && req.wdata[BIT_FAULT_KEEPER]
			&& !(bus_fault_o && fault_src[BIT_FAULT_KEEPER]) |=>
			!fault_stat_reg[BIT_FAULT_KEEPER])
		else $error("keeper fault flag not cleared");

	a_run_mode: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_reg)
		ce_i && pmode_i == PCG_RUN |=>
			watchdog_clock_enable_o == $past(run_gate_reg[BIT_WDOG])
			&& keeper_clock_enable_o
			== $past(run_gate_reg[BIT_KEEPER]))
		else $error("run mode not using run gating");

	a_deep_run: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_reg)
		ce_i && pmode_i == PCG_DEEP |=>
			watchdog_clock_enable_o == $past(run_gate_reg[BIT_WDOG]))
		else $error("deep sleep not using run gating");

	a_sleep_keeper: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_reg)
		ce_i && auto_gating_select && pmode_i == PCG_SLEEP |=>
			keeper_clock_enable_o
			== $past(sleep_gate_reg[BIT_KEEPER]))
		else $error("sleep gating not applied to keeper");

	a_reset_outputs: assert property (@(posedge core_clk_i)
		$rose(rst_b_reg) |-> keeper_clock_enable_o
			&& !watchdog_clock_enable_o && !bus_fault_o
			&& reg_rdata_o == ZERO_WORD && mode_reg == ZERO_WORD)
		else $error("outputs wrong as reset ends");
endmodule

// *** bench/pcg_unit_model.sv ***
`timescale 1ns/1ps
module pcg_unit_model (
	input wire logic clk_i,
	output logic keeper_acc_o,
	output logic wdog_acc_o
);
	initial begin
		keeper_acc_o = 1'b0;
		wdog_acc_o = 1'b0;
	end
	// One access cycle for each call; the units never stall the bus.
	task automatic touch(input logic k, input logic w);
		@(posedge clk_i);
		keeper_acc_o <= k;
		wdog_acc_o <= w;
		@(posedge clk_i);
		keeper_acc_o <= 1'b0;
		wdog_acc_o <= 1'b0;
	endtask
endmodule

// *** bench/peripheral_clock_gating_test.sv ***
`timescale 1ns/1ps
module peripheral_clock_gating_test;
	import pcg_pkg::*;
	logic clk, rst_b, ce, wr, rd, k_acc, w_acc, k_en, w_en, fault;
	logic [11:0] addr;
	logic [31:0] wdata, rdata;
	pcg_pmode_e pmode;
	int fails = 0;
	int samples_checked = 0;
	int cycles = 0;
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	pcg_unit_model units (.clk_i(clk), .keeper_acc_o(k_acc),
		.wdog_acc_o(w_acc));
	pcg_top DUT (.core_clk_i(clk), .rst_b_i(rst_b), .ce_i(ce),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .pmode_i(pmode),
		.keeper_acc_i(k_acc), .wdog_acc_i(w_acc),
		.keeper_clock_enable_o(k_en), .watchdog_clock_enable_o(w_en),
		.bus_fault_o(fault));
	task automatic tally_and_finish();
		$display("Checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk("rdata", rdata, e);
		@(posedge clk);
		#1;
		chk("rdata_idle", rdata, 32'h00000000);
	endtask
	// Enables trail the selected register by one cycle; allow two edges.
	task automatic en_is(input logic ke, input logic we);
		repeat (2) @(posedge clk);
		#1;
		chk("keeper_en", {31'h0, k_en}, {31'h0, ke});
		chk("wdog_en", {31'h0, w_en}, {31'h0, we});
	endtask
	task automatic touch_is(input logic k, input logic w, input logic f);
		units.touch(k, w);
		#1;
		chk("fault", {31'h0, fault}, {31'h0, f});
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			fails++;
			tally_and_finish();
		end
	end
	initial begin
		rst_b = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 12'h000;
		wdata = 32'h00000000;
		pmode = PCG_RUN;
		ce = 1'b1;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		en_is(1'b1, 1'b0);
		rd_reg(12'h100, 32'h00000040);
		rd_reg(12'h110, 32'h00000040);
		rd_reg(12'h104, 32'h00000000);
		wr_reg(12'h100, 32'hFFFFFFFF);
		rd_reg(12'h100, 32'h00000048);
		en_is(1'b1, 1'b1);
		touch_is(1'b1, 1'b1, 1'b0);
		// Software gates the keeper off, keeps the watchdog on, then touches each.
		wr_reg(12'h100, 32'h00000008);
		en_is(1'b0, 1'b1);
		touch_is(1'b1, 1'b0, 1'b1);
		touch_is(1'b0, 1'b1, 1'b0);
		rd_reg(12'h1F4, 32'h00000001);
		wr_reg(12'h1F4, 32'h00000001);
		rd_reg(12'h1F4, 32'h00000000);
		wr_reg(12'h110, 32'h00000040);
		@(posedge clk);
		pmode <= PCG_SLEEP;
		en_is(1'b0, 1'b1);
		wr_reg(12'h1F0, 32'h00000001);
		en_is(1'b1, 1'b0);
		rd_reg(12'h1F0, 32'h00000001);
		touch_is(1'b0, 1'b1, 1'b1);
		rd_reg(12'h1F4, 32'h00000002);
		@(posedge clk);
		pmode <= PCG_DEEP;
		en_is(1'b0, 1'b1);
		// While frozen, neither the write nor the mode change may land.
		@(posedge clk);
		ce <= 1'b0;
		pmode <= PCG_SLEEP;
		wr_reg(12'h100, 32'h00000040);
		en_is(1'b0, 1'b1);
		@(posedge clk);
		ce <= 1'b1;
		rd_reg(12'h100, 32'h00000008);
		en_is(1'b1, 1'b0);
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		rd_reg(12'h100, 32'h00000040);
		rd_reg(12'h1F0, 32'h00000000);
		en_is(1'b1, 1'b0);
		tally_and_finish();
	end
endmodule
